// ===== pkg/pswe_defs.svh
// Constants for the power state and wake-up event block
`ifndef PSWE_DEFS_SVH
`define PSWE_DEFS_SVH
// Wake source flag bit positions
`define PSWE_WSF_ITIM 0
`define PSWE_WSF_EXT 1
`define PSWE_WSF_CD 2
`define PSWE_WSF_SYNC 3
`define PSWE_WSF_PM0 4
`define PSWE_WSF_PM1 5
`define PSWE_WSF_EOM 6
`define PSWE_WSF_BF 7
`define PSWE_WSF_W 8
// Resume event flag bit positions
`define PSWE_REF_T0 0
`define PSWE_REF_T1 1
`define PSWE_REF_EBE 2
`define PSWE_REF_ESE 3
`define PSWE_REF_ST 4
`define PSWE_REF_W 5
// Reset values
`define PSWE_WSF_RST 8'h00
`define PSWE_REF_RST 5'h00
`endif

// ===== pkg/pswe_pkg.sv
// Types for the power state and wake-up event block
package pswe_pkg;
  typedef enum logic [2:0] {
    PSWE_RUN,
    PSWE_IDLE,
    PSWE_DEEP_IDLE,
    PSWE_POWERDOWN,
    PSWE_TX_LP,
    PSWE_THERMAL_SD
  } pswe_state_t;
endpackage : pswe_pkg

// ===== rtl/pswe_ctrl.sv
// Power state sequencer with wake-up and resume event flags
// Function
// - TX low power: slow and fast oscillators and TX machine run; RF on demand
// - TX low power exits only on interval expiry or transmission end
// - Thermal shutdown keeps only temperature detector and wake controller, waits normal temp
// - Idle halts the CPU; resume continues after the idle entry point
// - Deep idle powers CPU off; resume restarts from reset vector
// - Thermal shutdown powers CPU off; resume restarts from reset vector
// - Only run state accepts firmware state requests; others leave by hardware events
// - Each wake, resume and ADC event source has an indicator flag and a mask flag
// - Event sets its indicator flag when powered, regardless of mask
// - Mask only decides whether the event wakes or resumes
// - External pin flag raised except in thermal shutdown; wakes except from TX low power and thermal shutdown
// - LF receiver events behave like the external pin event
// - Timer and sampling flags: cleared powerdown, held deep idle/TX, raised idle/run
// - Encoder empty flags: cleared powerdown, held deep idle, raised idle/run
// - Encoder empty flags only meaningful in CPU transmission mode
// - ADC end: cleared powerdown, held deep idle, no wake in TX, resumes idle
// - Four origin flags record which low-power state other than idle was left
// - Pending wake flag on any unmasked wake event in every state
// - Pending resume flag on unmasked resume event in TX low power, idle, run
// - Interval timer wake is unmaskable and works in every low-power state except thermal shutdown
// - Reading wake source flags clears them all; several may stack
`timescale 1ns/100ps
`default_nettype none
`include "pswe_defs.svh"
module pswe_ctrl
  import pswe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Firmware state requests, honoured in run state only, then temperature levels and CPU TX mode
  input wire logic req_idle,
  input wire logic req_deep_idle,
  input wire logic req_powerdown,
  input wire logic req_tx_lp,
  input wire logic overtemp,
  input wire logic temp_normal,
  input wire logic cpu_tx_mode,
  // Event sources, one-cycle pulses, and external pin polarity
  input wire logic interval_expiry,
  input wire logic external_wake_pin,
  input wire logic ext_pin_high_active,
  input wire logic [5:0] lf_events,
  input wire logic tx_end,
  input wire logic [4:0] resume_events,
  input wire logic adc_end,
  input wire logic sampling_powerup,
  // Masks, one per flag
  input wire logic [`PSWE_WSF_W-1:0] wake_mask,
  input wire logic [`PSWE_REF_W-1:0] resume_mask,
  input wire logic adc_mask,
  // Flag readback and clears
  input wire logic wake_source_flags_rd,
  input wire logic device_status_rd,
  input wire logic resume_flags_rd,
  output logic [`PSWE_WSF_W-1:0] wake_source_flags,
  output logic [`PSWE_REF_W-1:0] resume_event_flags,
  output logic adc_end_flag,
  output logic woke_from_powerdown_flag,
  output logic thermal_resume_flag,
  output logic deep_idle_resume_flag,
  output logic tx_lowpower_resume_flag,
  output logic wake_pending_flag,
  output logic resume_pending_flag,
  // Power and CPU control
  output pswe_state_t power_state,
  output logic cpu_halt,
  output logic cpu_power_on,
  output logic cpu_restart_vector,
  output logic fast_osc_on,
  output logic tx_fsm_on,
  output logic rf_power_on,
  output logic slow_osc_select,
  input wire logic tx_rf_needed
);

  pswe_state_t state_reg, state_next;
  logic [`PSWE_WSF_W-1:0] wsf_reg, wsf_next;
  logic [`PSWE_REF_W-1:0] ref_reg, ref_next;
  logic adc_reg, adc_next;
  logic [3:0] origin_reg, origin_next;
  logic wpend_reg, rpend_reg, restart_reg;

  // Raw wake-source events, interval timer at bit 0
  wire logic ext_event = external_wake_pin == ext_pin_high_active;
  wire logic [`PSWE_WSF_W-1:0] wake_ev = {lf_events, ext_event, interval_expiry};
  // Encoder empties carry no meaning under the transmission controller
  wire logic [`PSWE_REF_W-1:0] res_ev = resume_events & {1'b1, {2{cpu_tx_mode}}, 2'b11};
  wire logic in_run = state_reg == PSWE_RUN;
  wire logic in_idle = state_reg == PSWE_IDLE;
  wire logic in_pd = state_reg == PSWE_POWERDOWN;
  wire logic in_di = state_reg == PSWE_DEEP_IDLE;
  wire logic in_txlp = state_reg == PSWE_TX_LP;
  wire logic in_tsd = state_reg == PSWE_THERMAL_SD;

  // Interval mask bit ignored for fail-safe reasons
  wire logic [`PSWE_WSF_W-1:0] eff_wmask = wake_mask & ~`PSWE_WSF_W'(1);
  wire logic [`PSWE_WSF_W-1:0] unmasked_w = wake_ev & ~eff_wmask;
  wire logic [`PSWE_REF_W-1:0] unmasked_r = res_ev & ~resume_mask;
  // Resume sources shared by idle exit and the run-state pending flag
  wire logic res_hit = (|unmasked_r) | (adc_end & ~adc_mask);
  wire logic wake_any = |unmasked_w;
  // TX low power blocks all but interval and transmission end
  wire logic txlp_exit = interval_expiry | tx_end;
  wire logic pd_di_exit = wake_any | (in_di & sampling_powerup);
  wire logic idle_exit = wake_any | res_hit;
  wire logic tsd_exit = temp_normal;
  wire logic resume_any = (in_txlp & txlp_exit) | (in_idle & idle_exit)
    | (in_run & res_hit);

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PSWE_RUN:
      begin
        if (overtemp)
          state_next = PSWE_THERMAL_SD;
        else if (req_powerdown)
          state_next = PSWE_POWERDOWN;
        else if (req_deep_idle)
          state_next = PSWE_DEEP_IDLE;
        else if (req_tx_lp)
          state_next = PSWE_TX_LP;
        else if (req_idle)
          state_next = PSWE_IDLE;
      end
      PSWE_IDLE: if (idle_exit) state_next = PSWE_RUN;
      PSWE_DEEP_IDLE, PSWE_POWERDOWN: if (pd_di_exit) state_next = PSWE_RUN;
      PSWE_TX_LP: if (txlp_exit) state_next = PSWE_RUN;
      PSWE_THERMAL_SD: if (tsd_exit) state_next = PSWE_RUN;
      default: state_next = PSWE_RUN;
    endcase
  end

  // True on the cycle that leaves a sleeping state for run
  function automatic logic leave_sleep(input pswe_state_t cur, input pswe_state_t nxt);
    leave_sleep = (nxt == PSWE_RUN) && (cur != PSWE_RUN);
  endfunction : leave_sleep
  wire logic exiting = leave_sleep(state_reg, state_next);

  // Flag updates: set wins over read clear
  always_comb
  begin
    wsf_next = wake_source_flags_rd ? '0 : wsf_reg;
    wsf_next = wsf_next | (in_tsd ? '0 : wake_ev);
    ref_next = resume_flags_rd ? '0 : ref_reg;
    adc_next = resume_flags_rd ? 1'b0 : adc_reg;
    if (in_pd)
    begin
      ref_next = '0;
      adc_next = 1'b0;
    end
    else if (in_idle || in_run)
    begin
      ref_next = ref_next | res_ev;
      adc_next = adc_next | adc_end;
    end
    else if (in_txlp)
      adc_next = adc_next | adc_end;
    origin_next = device_status_rd ? 4'h0 : origin_reg;
    if (exiting)
      origin_next = origin_next | {in_txlp, in_di, in_tsd, in_pd};
  end

  // State and flag registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= PSWE_RUN;
      wsf_reg <= `PSWE_WSF_RST;
      ref_reg <= `PSWE_REF_RST;
      adc_reg <= 1'b0;
      origin_reg <= 4'h0;
      wpend_reg <= 1'b0;
      rpend_reg <= 1'b0;
      restart_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wsf_reg <= wsf_next;
      ref_reg <= ref_next;
      adc_reg <= adc_next;
      origin_reg <= origin_next;
      wpend_reg <= wake_any | (in_tsd & tsd_exit) | (wpend_reg & ~device_status_rd);
      rpend_reg <= resume_any | (rpend_reg & ~device_status_rd);
      restart_reg <= exiting & (in_di | in_tsd | in_pd);
    end
  end

  // Outputs
  assign wake_source_flags = wsf_reg;
  assign resume_event_flags = ref_reg;
  assign adc_end_flag = adc_reg;
  assign woke_from_powerdown_flag = origin_reg[0];
  assign thermal_resume_flag = origin_reg[1];
  assign deep_idle_resume_flag = origin_reg[2];
  assign tx_lowpower_resume_flag = origin_reg[3];
  assign wake_pending_flag = wpend_reg;
  assign resume_pending_flag = rpend_reg;
  assign power_state = state_reg;
  assign cpu_halt = in_idle;
  assign cpu_power_on = in_run | in_idle;
  assign cpu_restart_vector = restart_reg;
  assign slow_osc_select = ~(in_run | in_idle);
  assign fast_osc_on = ~in_tsd & ~in_pd;
  assign tx_fsm_on = in_run | in_idle | in_txlp;
  assign rf_power_on = tx_fsm_on & tx_rf_needed;

  // Checks
  a_txlp_exit_only: assert property (@(posedge clk) disable iff (reset)
    in_txlp && !txlp_exit |=> state_reg == PSWE_TX_LP)
    else $error("TX low power left without allowed event");
  a_flag_sets_masked: assert property (@(posedge clk) disable iff (reset)
    external_wake_pin == ext_pin_high_active && !in_tsd |=> wsf_reg[`PSWE_WSF_EXT])
    else $error("external flag not raised");
  a_interval_unmask: assert property (@(posedge clk) disable iff (reset)
    (in_pd || in_di) && interval_expiry |=> state_reg == PSWE_RUN)
    else $error("interval timer failed to wake");
  a_pd_clears_ref: assert property (@(posedge clk) disable iff (reset)
    in_pd |=> ref_reg == '0)
    else $error("resume flags not cleared in powerdown");
  a_run_only_req: assert property (@(posedge clk) disable iff (reset)
    in_idle && !idle_exit |=> in_idle)
    else $error("idle left without event");
  a_origin_pd: assert property (@(posedge clk) disable iff (reset)
    in_pd && pd_di_exit |=> woke_from_powerdown_flag && cpu_restart_vector)
    else $error("powerdown origin not recorded");
  a_wake_pend: assert property (@(posedge clk) disable iff (reset)
    wake_any |=> wake_pending_flag)
    else $error("wake pending not raised");
  a_read_clears: assert property (@(posedge clk) disable iff (reset)
    wake_source_flags_rd && !(|wake_ev) |=> wsf_reg == '0)
    else $error("read did not clear wake flags");
  a_rf_gate: assert property (@(posedge clk) disable iff (reset)
    in_txlp |-> rf_power_on == tx_rf_needed && slow_osc_select)
    else $error("TX low power power gating wrong");
  a_txlp_osc: assert property (@(posedge clk) disable iff (reset)
    in_txlp |-> fast_osc_on && tx_fsm_on)
    else $error("TX low power lost fast oscillator or TX machine");

  // CPU power per state
  a_idle_halts: assert property (@(posedge clk) disable iff (reset)
    in_idle |-> cpu_halt && cpu_power_on)
    else $error("idle does not halt a powered CPU");
  a_cpu_off_sleep: assert property (@(posedge clk) disable iff (reset)
    (in_di || in_tsd || in_pd) |-> !cpu_power_on)
    else $error("CPU powered in a deep sleeping state");
  a_di_restart: assert property (@(posedge clk) disable iff (reset)
    in_di && pd_di_exit |=> cpu_restart_vector && deep_idle_resume_flag)
    else $error("deep idle exit without restart");

  // Thermal shutdown holds until the temperature is normal; powerdown holds until a wake event
  a_tsd_stays: assert property (@(posedge clk) disable iff (reset)
    in_tsd && !temp_normal |=> in_tsd)
    else $error("thermal shutdown left too early");
  a_tsd_resume: assert property (@(posedge clk) disable iff (reset)
    in_tsd && temp_normal |=> cpu_restart_vector && thermal_resume_flag)
    else $error("thermal resume not recorded");
  a_tsd_osc_off: assert property (@(posedge clk) disable iff (reset)
    in_tsd |-> !fast_osc_on && !tx_fsm_on && !rf_power_on)
    else $error("circuits left on in thermal shutdown");
  a_pd_held: assert property (@(posedge clk) disable iff (reset)
    in_pd && !pd_di_exit |=> in_pd)
    else $error("powerdown left without event");

  // Flag behaviour per state
  a_adc_txlp: assert property (@(posedge clk) disable iff (reset)
    in_txlp && adc_end |=> adc_end_flag)
    else $error("ADC end not flagged in TX low power");
  a_pd_adc_clear: assert property (@(posedge clk) disable iff (reset)
    in_pd |=> !adc_end_flag)
    else $error("ADC end flag not cleared in powerdown");
  a_idle_resume: assert property (@(posedge clk) disable iff (reset)
    in_idle && unmasked_r[`PSWE_REF_T0] |=> in_run && resume_event_flags[`PSWE_REF_T0])
    else $error("timer event did not resume idle");
  a_di_hold_ref: assert property (@(posedge clk) disable iff (reset)
    in_di && !resume_flags_rd |=> $stable(ref_reg))
    else $error("resume flags changed in deep idle");
  a_enc_gated: assert property (@(posedge clk) disable iff (reset)
    !cpu_tx_mode |=> !$rose(ref_reg[`PSWE_REF_EBE]) && !$rose(ref_reg[`PSWE_REF_ESE]))
    else $error("encoder flag raised under transmission controller");
  a_ext_txlp: assert property (@(posedge clk) disable iff (reset)
    in_txlp && !txlp_exit && ext_event |=> in_txlp && wake_source_flags[`PSWE_WSF_EXT])
    else $error("external event mishandled in TX low power");
  a_lf_flag: assert property (@(posedge clk) disable iff (reset)
    !in_tsd && lf_events[0] |=> wake_source_flags[`PSWE_WSF_CD])
    else $error("carrier flag not raised");
  a_txlp_resume: assert property (@(posedge clk) disable iff (reset)
    in_txlp && tx_end |=> resume_pending_flag && tx_lowpower_resume_flag)
    else $error("TX low power resume not recorded");
  a_sampling_di: assert property (@(posedge clk) disable iff (reset)
    in_di && sampling_powerup |=> in_run)
    else $error("sampling power-up did not resume deep idle");

endmodule : pswe_ctrl
`default_nettype wire

// ===== tb/pswe_src_model.sv
// Event source model: one-cycle event pulses on request
`timescale 1ns/100ps
`default_nettype none
module pswe_src_model
(
  // Clock
  input wire logic clk,
  // Event pulses: 0 interval, 1 tx end, 7:2 lf, 12:8 resume, 13 adc, 14 sampling power-up
  output logic [14:0] events
);
  initial events = 15'h0000;
  // Launched on a falling edge so exactly one rising edge sees it
  task automatic fire(input logic [14:0] which);
    @(negedge clk);
    events = which;
    @(negedge clk);
    events = 15'h0000;
  endtask : fire
endmodule : pswe_src_model
`default_nettype wire

// ===== tb/pswe_tb.sv
// Self-checking bench for the power state and wake-up event block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pswe_pkg::*;
  logic clk, reset;
  logic [3:0] reqs; // {tx_lp, powerdown, deep_idle, idle}
  logic [2:0] lvl; // {temp_normal, overtemp, ext pin}
  logic [2:0] rds; // {resume, status, wake source}
  logic [7:0] wake_mask;
  logic [4:0] res_mask;
  logic adc_msk, tx_mode, rf_need;
  wire [14:0] ev;
  wire [7:0] wsf;
  wire [4:0] ref_flags;
  wire adc_f, pd_f, th_f, di_f, tx_f, wp_f, rp_f, halt, cpu_on, restart, fosc, txon, rfon, sosc;
  pswe_state_t st;
  int n_fail, comparisons;
  pswe_src_model i_pswe_src_model (.clk(clk), .events(ev));
  pswe_ctrl i_pswe_ctrl (.clk(clk), .reset(reset),
    .req_idle(reqs[0]), .req_deep_idle(reqs[1]), .req_powerdown(reqs[2]), .req_tx_lp(reqs[3]),
    .overtemp(lvl[1]), .temp_normal(lvl[2]), .cpu_tx_mode(tx_mode),
    .interval_expiry(ev[0]), .external_wake_pin(lvl[0]), .ext_pin_high_active(1'b1),
    .lf_events(ev[7:2]), .tx_end(ev[1]), .resume_events(ev[12:8]), .adc_end(ev[13]),
    .sampling_powerup(ev[14]), .wake_mask(wake_mask),
    .resume_mask(res_mask), .adc_mask(adc_msk),
    .wake_source_flags_rd(rds[0]), .device_status_rd(rds[1]), .resume_flags_rd(rds[2]),
    .wake_source_flags(wsf), .resume_event_flags(ref_flags), .adc_end_flag(adc_f),
    .woke_from_powerdown_flag(pd_f), .thermal_resume_flag(th_f), .deep_idle_resume_flag(di_f),
    .tx_lowpower_resume_flag(tx_f), .wake_pending_flag(wp_f), .resume_pending_flag(rp_f),
    .power_state(st), .cpu_halt(halt), .cpu_power_on(cpu_on), .cpu_restart_vector(restart),
    .fast_osc_on(fosc), .tx_fsm_on(txon), .rf_power_on(rfon), .slow_osc_select(sosc),
    .tx_rf_needed(rf_need));
  // Free-running 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  // Strobes last one cycle; results are read at the falling edge after
  task automatic req(input logic [3:0] r);
    @(negedge clk);
    reqs = r;
    @(negedge clk);
    reqs = 4'h0;
  endtask : req
  task automatic level(input logic [2:0] m);
    @(negedge clk);
    lvl = m;
    @(negedge clk);
    lvl = 3'h0;
  endtask : level
  task automatic read_all;
    @(negedge clk);
    rds = 3'h7;
    @(negedge clk);
    rds = 3'h0;
  endtask : read_all
  task automatic t_powerdown;
    wake_mask = 8'hff;
    req(4'h4);
    check(8'(st), 8'(PSWE_POWERDOWN));
    req(4'h1);
    check(8'(st), 8'(PSWE_POWERDOWN));
    level(3'h1);
    check(8'(st), 8'(PSWE_POWERDOWN));
    check(wsf, 8'h02);
    i_pswe_src_model.fire(15'h0001);
    check(8'(st), 8'(PSWE_RUN));
    check(wsf, 8'h03);
    check({6'h00, pd_f, wp_f}, 8'h03);
    read_all();
    check(wsf, 8'h00);
  endtask : t_powerdown
  task automatic t_deep_idle;
    wake_mask = 8'h00;
    req(4'h2);
    check({7'h00, cpu_on}, 8'h00);
    i_pswe_src_model.fire(15'h4000);
    check(8'(st), 8'(PSWE_RUN));
    check({6'h00, di_f, restart}, 8'h03);
    check({3'h0, ref_flags}, 8'h00);
    read_all();
  endtask : t_deep_idle
  task automatic t_tx_lowpower;
    req(4'h8);
    check({4'h0, fosc, txon, rfon, sosc}, 8'h0f);
    rf_need = 1'b0;
    i_pswe_src_model.fire(15'h0004);
    check(8'(st), 8'(PSWE_TX_LP));
    check(wsf, 8'h04);
    check({4'h0, fosc, txon, rfon, sosc}, 8'h0d);
    i_pswe_src_model.fire(15'h2000);
    check({4'h0, st, adc_f}, {4'h0, PSWE_TX_LP, 1'b1});
    rf_need = 1'b1;
    i_pswe_src_model.fire(15'h0002);
    check(8'(st), 8'(PSWE_RUN));
    check({6'h00, tx_f, rp_f}, 8'h03);
    read_all();
    check({7'h00, adc_f}, 8'h00);
  endtask : t_tx_lowpower
  task automatic t_idle;
    req(4'h1);
    check({6'h00, halt, cpu_on}, 8'h03);
    i_pswe_src_model.fire(15'h0100);
    check(8'(st), 8'(PSWE_RUN));
    check({3'h0, ref_flags}, 8'h01);
    check({5'h00, rp_f, pd_f, restart}, 8'h04);
    read_all();
  endtask : t_idle
  // Masked events set flags in idle without resuming it; gated encoder events set no flag
  task automatic t_masks;
    req(4'h1);
    res_mask = 5'h01;
    adc_msk = 1'b1;
    tx_mode = 1'b0;
    i_pswe_src_model.fire(15'h0100);
    check({4'h0, st, ref_flags[0]}, {4'h0, PSWE_IDLE, 1'b1});
    i_pswe_src_model.fire(15'h0800);
    check({4'h0, st, ref_flags[3]}, {4'h0, PSWE_IDLE, 1'b0});
    i_pswe_src_model.fire(15'h2000);
    check({4'h0, st, adc_f}, {4'h0, PSWE_IDLE, 1'b1});
    i_pswe_src_model.fire(15'h0200);
    check(8'(st), 8'(PSWE_RUN));
    check({2'h0, rp_f, ref_flags}, 8'h23);
    res_mask = 5'h00;
    adc_msk = 1'b0;
    tx_mode = 1'b1;
    read_all();
  endtask : t_masks
  task automatic t_thermal;
    level(3'h2);
    check({4'h0, st, cpu_on}, {4'h0, PSWE_THERMAL_SD, 1'b0});
    level(3'h4);
    check(8'(st), 8'(PSWE_RUN));
    check({6'h00, th_f, restart}, 8'h03);
  endtask : t_thermal
  task automatic conclude;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  // Watchdog: the sequence needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    conclude();
  end
  // Main sequence
  initial
  begin
    reset = 1'b1;
    reqs = 4'h0;
    lvl = 3'h0;
    rds = 3'h0;
    wake_mask = 8'h00;
    res_mask = 5'h00;
    adc_msk = 1'b0;
    tx_mode = 1'b1;
    rf_need = 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_powerdown();
    t_deep_idle();
    t_tx_lowpower();
    t_idle();
    t_masks();
    t_thermal();
    conclude();
  end
endmodule : testbench
`default_nettype wire
